// File: core/taiq_defs.svh
// timing counts, field positions, reset values and register offsets
`ifndef TAIQ_DEFS_SVH
`define TAIQ_DEFS_SVH
// register byte offsets
`define TAIQ_OFS_CTRL 12'h000
`define TAIQ_OFS_CHMAP 12'h004
`define TAIQ_OFS_SPTIME 12'h008
`define TAIQ_OFS_CMD 12'h00C
`define TAIQ_OFS_STAT 12'h010
`define TAIQ_OFS_GRP 12'h014
`define TAIQ_OFS_RBDATA 12'h018
// ctrl bit positions
`define TAIQ_CTRL_MAIN_POL 0
`define TAIQ_CTRL_USER_POL 1
`define TAIQ_CTRL_CTLRX_RETX 2
// cmd bit positions (write one to act)
`define TAIQ_CMD_SPARE_ON 0
`define TAIQ_CMD_HANGUP 1
`define TAIQ_CMD_RB_SEND 2
// channel map fields: four 2-bit source selectors, one per channel
`define TAIQ_CH_SPARE 2
`define TAIQ_CH_CTLRX 3
// reset values
`define TAIQ_CTRL_RST 3'h0
`define TAIQ_CHMAP_RST 8'h00
`define TAIQ_SPTIME_RST 16'h0BB8
// spare-audio timer tick: 1 ms at 100 MHz
`define TAIQ_TICK_NS 1000000
`define TAIQ_CLK_NS 10
`define TAIQ_TICK_CYC (`TAIQ_TICK_NS / `TAIQ_CLK_NS)
// serial bit period of the remote-base data stream
`define TAIQ_BIT_NS 1000
`define TAIQ_BIT_CYC (`TAIQ_BIT_NS / `TAIQ_CLK_NS)
`define TAIQ_RB_BITS 32
`endif

// File: core/taiq_pkg.sv
// types shared by the tone access qualifier files
package taiq_pkg;
   typedef enum logic [1:0] {
      TAIQ_SRC_NONE,
      TAIQ_SRC_LOCAL_MIC,
      TAIQ_SRC_CTLRX,
      TAIQ_SRC_OTHER
   } taiq_src_t;
   typedef enum {
      TAIQ_SH_IDLE,
      TAIQ_SH_WAIT,
      TAIQ_SH_SHIFT
   } taiq_sh_state_t;
endpackage

// File: core/taiq_sync.sv
// two-stage synchroniser with polarity correction after the second stage
`timescale 1ns/100ps
`default_nettype none
module taiq_sync (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // raw pin and its sense, 1 = high true
   input wire logic pin_raw,
   input wire logic active_high,
   // qualified level
   output logic active
);
   logic meta_q;
   logic sync_q;

   // first stage feeds only the second stage
   always_ff @(posedge clock) begin
      if (!nrst) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= pin_raw;
         sync_q <= meta_q;
      end
   end

   // polarity applied only after synchronisation
   assign active = active_high ? sync_q : ~sync_q;
endmodule
`default_nettype wire

// File: core/taiq_top.sv
// tone access qualifier, spare audio, recorder link and ahb-lite registers
//
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "taiq_defs.svh"
module taiq_top
   import taiq_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // external pins
   input wire logic main_tone_qualify,
   input wire logic user_tone_qualify,
   input wire logic carrier_detect,
   input wire logic config_switch3,
   input wire logic voice_recorder_busy,
   input wire logic local_mic_request,
   input wire logic other_decoder_request,
   // qualified results
   output logic user_qualified,
   output logic operator_qualified,
   output logic ctlrx_active,
   output logic [1:0] decoder_grant,
   output logic ctlrx_retransmit,
   output logic spare_tx_key,
   output logic spare_audio_route,
   // remote outputs and serial stream
   output logic [7:0] remote_group_a,
   output logic [7:0] remote_group_b,
   output logic rb_data,
   output logic rb_clock,
   output logic rb_strobe,
   output logic rb_busy
);
   // synchronised, polarity corrected inputs
   logic main_act, user_act, cd_act, busy_act;
   // registers
   logic [2:0] ctrl_q;
   logic [7:0] chmap_q;
   logic [15:0] sptime_q;
   logic [15:0] tone_q, tone_d;
   logic [15:0] freq_q, freq_d;
   logic sw3_q, sw3_meta_q;
   // ahb address phase capture
   logic wr_pend_q;
   logic [11:0] addr_q;
   // spare audio
   logic spare_on_q;
   logic [15:0] sp_cnt_q;
   logic [16:0] tick_q;
   // serial shifter
   taiq_sh_state_t sh_q;
   logic [31:0] sh_data_q;
   logic [5:0] sh_bits_q;
   logic [9:0] sh_div_q;
   logic sh_start_q;
   logic [31:0] rdata_d;

   // reg decode used both for reads and writes
   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      hit = (a == o);
   endfunction

   // channel map field extraction
   function automatic logic [1:0] chsel(input logic [7:0] m, input int ch);
      chsel = m[(ch - 1) * 2 +: 2];
   endfunction

   // input qualification, two stages each
   taiq_sync u_main (
      .clock(clock), .nrst(nrst),
      .pin_raw(main_tone_qualify),
      .active_high(ctrl_q[`TAIQ_CTRL_MAIN_POL]),
      .active(main_act)
   );
   taiq_sync u_user (
      .clock(clock), .nrst(nrst),
      .pin_raw(user_tone_qualify),
      .active_high(ctrl_q[`TAIQ_CTRL_USER_POL]),
      .active(user_act)
   );
   taiq_sync u_cd (
      .clock(clock), .nrst(nrst),
      .pin_raw(carrier_detect),
      .active_high(sw3_q),
      .active(cd_act)
   );
   taiq_sync u_busy (
      .clock(clock), .nrst(nrst),
      .pin_raw(voice_recorder_busy),
      .active_high(1'b1),
      .active(busy_act)
   );

   // switch strap, synchronised like the tone, carrier and busy pins; pulled-low idle reads
   // inactive only when the switch is on, so fit it on with no receiver
   always_ff @(posedge clock) begin
      if (!nrst) begin
         sw3_meta_q <= 1'b0;
         sw3_q <= 1'b0;
      end else begin
         sw3_meta_q <= config_switch3;
         sw3_q <= sw3_meta_q;
      end
   end

   // bus decode
   wire addr_ok = hsel & hready & htrans[1];
   wire wr_go = wr_pend_q;
   wire is_ctrl = hit(addr_q, `TAIQ_OFS_CTRL);
   wire is_chmap = hit(addr_q, `TAIQ_OFS_CHMAP);
   wire is_sptime = hit(addr_q, `TAIQ_OFS_SPTIME);
   wire is_cmd = hit(addr_q, `TAIQ_OFS_CMD);
   wire is_grp = hit(addr_q, `TAIQ_OFS_GRP);
   wire is_rbd = hit(addr_q, `TAIQ_OFS_RBDATA);
   wire cmd_spare = wr_go & is_cmd & hwdata[`TAIQ_CMD_SPARE_ON];
   wire cmd_hangup = wr_go & is_cmd & hwdata[`TAIQ_CMD_HANGUP];
   wire cmd_rbsend = wr_go & is_cmd & hwdata[`TAIQ_CMD_RB_SEND];
   wire tick = (tick_q == 17'(`TAIQ_TICK_CYC - 1));
   wire sp_expire = spare_on_q & tick & (sp_cnt_q == 16'h0001);

   // bus address phase; answer is always zero wait, okay
   always_ff @(posedge clock) begin
      if (!nrst) begin
         wr_pend_q <= 1'b0;
         addr_q <= 12'h000;
      end else begin
         wr_pend_q <= addr_ok & hwrite;
         if (addr_ok) begin
            addr_q <= {haddr[11:2], 2'b00};
         end
      end
   end

   // configuration registers
   always_ff @(posedge clock) begin
      if (!nrst) begin
         ctrl_q <= `TAIQ_CTRL_RST;
         chmap_q <= `TAIQ_CHMAP_RST;
         sptime_q <= `TAIQ_SPTIME_RST;
      end else begin
         if (wr_go & is_ctrl) begin
            ctrl_q <= hwdata[2:0];
         end
         if (wr_go & is_chmap) begin
            chmap_q <= hwdata[7:0];
         end
         if (wr_go & is_sptime) begin
            sptime_q <= hwdata[15:0];
         end
      end
   end

   // remote groups: one write loads all eight bits of a group together
   always_ff @(posedge clock) begin
      if (!nrst) begin
         remote_group_a <= 8'h00;
         remote_group_b <= 8'h00;
      end else if (wr_go & is_grp) begin
         remote_group_a <= hwdata[7:0];
         remote_group_b <= hwdata[15:8];
      end
   end

   // remote-base memory entry: tone bits beside frequency
   assign tone_d = (wr_go & is_rbd) ? hwdata[31:16] : tone_q;
   assign freq_d = (wr_go & is_rbd) ? hwdata[15:0] : freq_q;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         tone_q <= 16'h0000;
         freq_q <= 16'h0000;
      end else begin
         tone_q <= tone_d;
         freq_q <= freq_d;
      end
   end

   // spare audio on/off with limit timer; hangup beats a new start, and a
   // new start beats an expiry in the same cycle, so the count is reloaded
   always_ff @(posedge clock) begin
      if (!nrst) begin
         spare_on_q <= 1'b0;
         sp_cnt_q <= 16'h0000;
         tick_q <= 17'h00000;
      end else begin
         tick_q <= (tick | ~spare_on_q) ? 17'h00000 : tick_q + 17'h00001;
         if (cmd_hangup) begin
            spare_on_q <= 1'b0;
         end else if (cmd_spare) begin
            spare_on_q <= 1'b1;
            sp_cnt_q <= sptime_q;
         end else if (sp_expire) begin
            spare_on_q <= 1'b0;
         end else if (spare_on_q & tick & (sp_cnt_q != 16'h0000)) begin
            sp_cnt_q <= sp_cnt_q - 16'h0001;
         end
      end
   end

   // serial stream to the remote base and recorder; waits for busy to clear before the frame starts
   always_ff @(posedge clock) begin
      if (!nrst) begin
         sh_q <= TAIQ_SH_IDLE;
         sh_data_q <= 32'h00000000;
         sh_bits_q <= 6'h00;
         sh_div_q <= 10'h000;
         sh_start_q <= 1'b0;
      end else begin
         sh_start_q <= cmd_rbsend;
         case (sh_q)
            TAIQ_SH_IDLE: begin
               if (sh_start_q) begin
                  sh_data_q <= {tone_q, freq_q};
                  sh_q <= TAIQ_SH_WAIT;
               end
            end
            TAIQ_SH_WAIT: begin
               if (!busy_act) begin
                  sh_bits_q <= 6'(`TAIQ_RB_BITS);
                  sh_div_q <= 10'h000;
                  sh_q <= TAIQ_SH_SHIFT;
               end
            end
            TAIQ_SH_SHIFT: begin
               if (sh_div_q == 10'(`TAIQ_BIT_CYC - 1)) begin
                  sh_div_q <= 10'h000;
                  sh_data_q <= {sh_data_q[30:0], 1'b0};
                  sh_bits_q <= sh_bits_q - 6'h01;
                  if (sh_bits_q == 6'h01) begin
                     sh_q <= TAIQ_SH_IDLE;
                  end
               end else begin
                  sh_div_q <= sh_div_q + 10'h001;
               end
            end
            default: begin
               sh_q <= TAIQ_SH_IDLE;
            end
         endcase
      end
   end

   // qualification and arbitration outputs, all registered
   wire ctlrx_mapped = chsel(chmap_q, 4) == 2'(`TAIQ_CH_CTLRX);
   wire spare_mapped = chsel(chmap_q, 3) == 2'(`TAIQ_CH_SPARE);
   wire rx_req = cd_act & ctlrx_mapped;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         user_qualified <= 1'b0;
         operator_qualified <= 1'b0;
         ctlrx_active <= 1'b0;
         decoder_grant <= TAIQ_SRC_NONE;
         ctlrx_retransmit <= 1'b0;
         spare_tx_key <= 1'b0;
         spare_audio_route <= 1'b0;
      end else begin
         user_qualified <= main_act | user_act;
         operator_qualified <= main_act;
         ctlrx_active <= rx_req;
         if (local_mic_request) begin
            decoder_grant <= TAIQ_SRC_LOCAL_MIC;
         end else if (rx_req) begin
            decoder_grant <= TAIQ_SRC_CTLRX;
         end else if (other_decoder_request) begin
            decoder_grant <= TAIQ_SRC_OTHER;
         end else begin
            decoder_grant <= TAIQ_SRC_NONE;
         end
         ctlrx_retransmit <= rx_req & ctrl_q[`TAIQ_CTRL_CTLRX_RETX];
         spare_tx_key <= spare_on_q;
         spare_audio_route <= spare_on_q & spare_mapped;
      end
   end

   // read data is picked from haddr in the address phase so that it
   // already stands in the data phase with no wait state; the cost is
   // that a read straight after a write to the same word sees old data
   wire [11:0] rd_addr = {haddr[11:2], 2'b00};
   assign rdata_d = hit(rd_addr, `TAIQ_OFS_CTRL) ? {29'h0, ctrl_q} :
                    hit(rd_addr, `TAIQ_OFS_CHMAP) ? {24'h0, chmap_q} :
                    hit(rd_addr, `TAIQ_OFS_SPTIME) ? {16'h0, sptime_q} :
                    hit(rd_addr, `TAIQ_OFS_STAT) ?
                       {25'h0, sh_q != TAIQ_SH_IDLE, busy_act, spare_on_q,
                        cd_act, user_act, main_act, sw3_q} :
                    hit(rd_addr, `TAIQ_OFS_GRP) ?
                       {16'h0, remote_group_b, remote_group_a} :
                    hit(rd_addr, `TAIQ_OFS_RBDATA) ? {tone_q, freq_q} :
                    32'h00000000;

   // serial pins and bus read data registered
   always_ff @(posedge clock) begin
      if (!nrst) begin
         rb_data <= 1'b0;
         rb_clock <= 1'b0;
         rb_strobe <= 1'b0;
         rb_busy <= 1'b0;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         rb_data <= (sh_q == TAIQ_SH_SHIFT) & sh_data_q[31];
         rb_clock <= (sh_q == TAIQ_SH_SHIFT) &
                     (sh_div_q >= 10'(`TAIQ_BIT_CYC / 2));
         rb_strobe <= (sh_q == TAIQ_SH_SHIFT) & (sh_bits_q == 6'h01) &
                      (sh_div_q == 10'(`TAIQ_BIT_CYC - 1));
         rb_busy <= (sh_q != TAIQ_SH_IDLE);
         if (addr_ok & ~hwrite) begin
            hrdata <= rdata_d; // stands until the next read is taken
         end
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// File: bench/taiq_partner.sv
// far-side model: tone decoders, control receiver and voice recorder
`timescale 1ns/100ps
`default_nettype none
module taiq_partner (
   // serial recorder link from the block
   input wire logic rb_data,
   input wire logic rb_clock,
   // decoder, receiver and recorder pins
   output logic main_tone_qualify,
   output logic user_tone_qualify,
   output logic carrier_detect,
   output logic voice_recorder_busy,
   // captured recorder stream
   output logic [31:0] rx_word,
   output logic [7:0] rx_count
);
   // idle pins read low, as the pull-downs leave them
   initial begin
      main_tone_qualify = 1'b0;
      user_tone_qualify = 1'b0;
      carrier_detect = 1'b0;
      voice_recorder_busy = 1'b0;
      rx_word = 32'h0;
      rx_count = 8'h0;
   end
   // recorder shifts control bits in on each bit clock rise
   always @(posedge rb_clock) begin
      rx_word <= {rx_word[30:0], rb_data};
      rx_count <= rx_count + 8'h1;
   end
   // decoder outputs are plain levels, changed just after an edge
   task automatic set_pins(input logic m, input logic u, input logic c);
      main_tone_qualify <= m;
      user_tone_qualify <= u;
      carrier_detect <= c;
   endtask
   // recorder reports busy, the block must wait on it
   task automatic set_busy(input logic b);
      voice_recorder_busy <= b;
   endtask
endmodule
`default_nettype wire

// File: bench/taiq_chk.sv
// port-level assertions for the tone access qualifier
`timescale 1ns/100ps
`default_nettype none
module taiq_chk (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // decoder requests
   input wire logic local_mic_request,
   input wire logic other_decoder_request,
   // qualified results
   input wire logic user_qualified,
   input wire logic operator_qualified,
   input wire logic ctlrx_active,
   input wire logic [1:0] decoder_grant,
   input wire logic ctlrx_retransmit,
   input wire logic spare_tx_key,
   input wire logic spare_audio_route,
   // serial stream
   input wire logic rb_data,
   input wire logic rb_clock,
   input wire logic rb_busy
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   oper_user_a: assert property (
      operator_qualified |-> user_qualified)
      else $error("operator qualified without user");
   mic_first_a: assert property (
      $past(nrst) && $past(local_mic_request) |-> decoder_grant == 2'h1)
      else $error("local mic not granted");
   other_last_a: assert property (
      decoder_grant == 2'h3
      |-> $past(other_decoder_request) && !$past(local_mic_request))
      else $error("other source granted wrongly");
   no_req_grant_a: assert property (
      $past(nrst) && !$past(local_mic_request)
      && !$past(other_decoder_request)
      |-> decoder_grant inside {2'h0, 2'h2})
      else $error("grant without request");
   retx_rx_a: assert property (
      ctlrx_retransmit |-> ctlrx_active)
      else $error("retransmit without control receiver");
   route_key_a: assert property (
      spare_audio_route |-> spare_tx_key)
      else $error("spare audio routed while unkeyed");
   clk_frame_a: assert property (
      rb_clock |-> rb_busy)
      else $error("bit clock outside frame");
   bit_hold_a: assert property (
      $rose(rb_clock) |-> $stable(rb_data)[*8])
      else $error("serial data moved in clock high");
endmodule
`default_nettype wire
bind taiq_top taiq_chk u_taiq_chk (.clock, .nrst, .local_mic_request,
   .other_decoder_request, .user_qualified, .operator_qualified,
   .ctlrx_active, .decoder_grant, .ctlrx_retransmit, .spare_tx_key,
   .spare_audio_route, .rb_data, .rb_clock, .rb_busy);

// File: bench/taiq_tb.sv
// self-checking bench for the tone access qualifier
`timescale 1ns/100ps
`default_nettype none
`include "taiq_defs.svh"
module taiq_tb;
   logic clock, nrst, hwrite, config_switch3, local_mic_request;
   logic other_decoder_request, m, ca;
   logic [11:0] haddr;
   logic [1:0] htrans, decoder_grant;
   logic [31:0] hwdata, hrdata, rdat, r, seed;
   logic [7:0] remote_group_a, remote_group_b, rx_count;
   logic [31:0] rx_word;
   logic hreadyout, hresp, user_qualified, operator_qualified, ctlrx_active;
   logic ctlrx_retransmit, spare_tx_key, spare_audio_route, rb_data, rb_clock;
   logic rb_strobe, rb_busy, main_tone_qualify, user_tone_qualify;
   logic carrier_detect, voice_recorder_busy;
   int checked, miscompares, i, g, strobes;
   // design and far side; hready is the one slave's hreadyout
   taiq_top u_taiq_top (.clock, .nrst, .hsel(1'b1), .haddr, .htrans,
      .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
      .hreadyout, .hresp, .main_tone_qualify, .user_tone_qualify,
      .carrier_detect, .config_switch3, .voice_recorder_busy,
      .local_mic_request, .other_decoder_request, .user_qualified,
      .operator_qualified, .ctlrx_active, .decoder_grant, .ctlrx_retransmit,
      .spare_tx_key, .spare_audio_route, .remote_group_a, .remote_group_b,
      .rb_data, .rb_clock, .rb_strobe, .rb_busy);
   taiq_partner u_partner (.rb_data, .rb_clock, .main_tone_qualify,
      .user_tone_qualify, .carrier_detect, .voice_recorder_busy, .rx_word,
      .rx_count);
   // 100 MHz clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] s);
      checked++;
      if (s !== e) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   // one single ahb-lite transfer; read data is taken at the data edge
   task automatic bus(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
      rdat = hrdata;
   endtask
   task automatic end_sim;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // frame end strobes, sampled at the edge before they move
   always @(posedge clock) begin
      if (rb_strobe === 1'b1) begin
         strobes++;
      end
   end
   // watchdog: 1 ms limit timer plus one short frame, with margin
   initial begin
      repeat (120000) @(posedge clock);
      miscompares++;
      end_sim();
   end
   initial begin
      seed = 32'h1b26;
      {nrst, hwrite, htrans, haddr, hwdata} = '0;
      {config_switch3, local_mic_request, other_decoder_request} = '0;
      repeat (4) @(posedge clock);
      nrst <= 1'b1;
      bus(0, `TAIQ_OFS_SPTIME, 0);
      chk("sptime", `TAIQ_SPTIME_RST, rdat);
      bus(0, `TAIQ_OFS_CHMAP, 0);
      chk("chmap", `TAIQ_CHMAP_RST, rdat);
      bus(0, 12'h020, 0);
      chk("unmapped", 0, rdat);
      bus(1, `TAIQ_OFS_CHMAP, 32'hE0);
      // random pin levels, polarities and requests against the model
      for (i = 0; i < 24; i++) begin
         r = $random(seed);
         bus(1, `TAIQ_OFS_CTRL, {29'h0, r[2:0]});
         config_switch3 <= r[3];
         local_mic_request <= r[7];
         other_decoder_request <= r[8];
         u_partner.set_pins(r[4], r[5], r[6]);
         repeat (6) @(posedge clock);
         m = (r[4] == r[0]);
         ca = (r[6] == r[3]);
         g = r[7] ? 1 : ca ? 2 : r[8] ? 3 : 0;
         chk("user", m | (r[5] == r[1]), user_qualified);
         chk("oper", m, operator_qualified);
         chk("ctlrx", ca, ctlrx_active);
         chk("retx", ca & r[2], ctlrx_retransmit);
         chk("grant", g, decoder_grant);
      end
      // spare audio: hangup, joint start and hangup, then limit timer
      bus(1, `TAIQ_OFS_SPTIME, 0);
      bus(1, `TAIQ_OFS_CMD, 1);
      repeat (50) @(posedge clock);
      chk("key", 3, {spare_tx_key, spare_audio_route});
      bus(1, `TAIQ_OFS_CMD, 2);
      repeat (4) @(posedge clock);
      chk("hangup", 0, {spare_tx_key, spare_audio_route});
      bus(1, `TAIQ_OFS_CMD, 3);
      repeat (4) @(posedge clock);
      chk("joint", 0, spare_tx_key);
      bus(1, `TAIQ_OFS_SPTIME, 1);
      bus(1, `TAIQ_OFS_CMD, 1);
      repeat (4) @(posedge clock);
      chk("key", 3, {spare_tx_key, spare_audio_route});
      for (i = 0; i < 101000 && spare_tx_key === 1'b1; i++) @(posedge clock);
      chk("timer", 0, spare_tx_key);
      r = $random(seed);
      bus(1, `TAIQ_OFS_GRP, r);
      repeat (2) @(posedge clock);
      chk("group", r[15:0], {remote_group_b, remote_group_a});
      chk("hresp", 0, hresp);
      // recorder busy holds the stream back, then all 32 bits arrive
      u_partner.set_busy(1);
      bus(1, `TAIQ_OFS_RBDATA, r);
      bus(1, `TAIQ_OFS_CMD, 4);
      repeat (300) @(posedge clock);
      chk("paced", 0, rx_count);
      u_partner.set_busy(0);
      for (i = 0; i < 5000 && rx_count != 8'd32; i++) @(posedge clock);
      chk("count", 32, rx_count);
      chk("stream", r, rx_word);
      repeat (100) @(posedge clock);
      chk("strobe", 1, strobes);
      end_sim();
   end
endmodule
`default_nettype wire
